/* src/pda_consts.svh */
/*
  Constants for the program space data access bridge: register offsets,
  reset values, field positions and window timing.
  Assumes it is included by the bridge module only; the package does not include it.
*/
`ifndef PDA_CONSTS_SVH
`define PDA_CONSTS_SVH

`define PDA_OFS_TBL_PAGE   8'h00
`define PDA_OFS_RD_PAGE    8'h04
`define PDA_OFS_WR_PAGE    8'h08
`define PDA_OFS_IRQ_STS    8'h0C
`define PDA_OFS_IRQ_MASK   8'h10
`define PDA_OFS_STATE      8'h14

`define PDA_RST_TBL_PAGE   8'h00
`define PDA_RST_RD_PAGE    10'h000
`define PDA_RST_WR_PAGE    10'h000
`define PDA_RST_IRQ        2'h0

`define PDA_IRQ_TRAP       0
`define PDA_IRQ_CFG_WR     1

`define PDA_TBL_CFG_BIT    7
`define PDA_RD_WIN_BIT     9
`define PDA_RD_HI_BIT      8
`define PDA_EA_WIN_BIT     15

`define PDA_EXTRA_MOV      2'h1
`define PDA_EXTRA_OTHER    2'h2
`define PDA_EXTRA_RPT_EDGE 2'h2
`define PDA_EXTRA_RPT_MID  2'h0

`define PDA_RESP_OKAY      2'h0
`define PDA_RESP_SLVERR    2'h2

`endif

/* src/pda_pkg.sv */
/*
  Types of the program space data access bridge: request kinds, states,
  and the structs carried between the core, the bridge and program memory.
  Assumes pda_consts.svh is on the include path.
*/
`default_nettype none

package pda_pkg;

  typedef enum logic [2:0] {
    PDA_TABLE_READ_LOW,
    PDA_TABLE_READ_HIGH,
    PDA_TABLE_WRITE_LOW,
    PDA_TABLE_WRITE_HIGH,
    PDA_DATA_READ,
    PDA_DATA_WRITE
  } pda_kind_t;

  typedef enum logic [1:0] {
    PDA_IDLE,
    PDA_MEM,
    PDA_EXTRA
  } pda_state_t;

  typedef struct packed {
    pda_kind_t   kind;
    logic        byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic        is_mov;
    logic        in_repeat;
    logic        repeat_edge;
  } pda_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        trap;
    logic        passthru;
    logic        refused;
  } pda_resp_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        we;
    logic [2:0]  wstrb;
    logic [23:0] wdata;
    logic        cfg;
  } pda_pm_req_t;

  typedef struct packed {
    pda_state_t  st;
    logic [1:0]  cnt;
    logic        hi;
    logic        bm;
    logic        bs;
    logic        rd;
    logic        pm_valid;
    pda_pm_req_t pm;
    logic        resp_valid;
    pda_resp_t   resp;
    logic [7:0]  tbl_page;
    logic [9:0]  rd_page;
    logic [9:0]  wr_page;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_mask;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pda_regs_t;

endpackage : pda_pkg

`default_nettype wire

/* src/pda_bridge.sv */
/*
  Program space data access bridge: table reads and writes through a page
  register, a read-only window of program memory in the upper data half,
  address error trap, AXI4-Lite register slave and a masked interrupt.
  Assumes the core holds a request until it is taken, and that program
  memory answers each request with a one-cycle ack carrying read data.
*/
`default_nettype none
`include "pda_consts.svh"

// Summary of operation
// RULE1: Word table read low returns bits 15:0
// RULE2: Byte table read low picks byte by select
// RULE3: Word table read high: bits 23:16, zero upper
// RULE4: Byte table read high; phantom byte reads zero
// RULE5: Low and high spaces share one address
// RULE6: Program address steps two per word
// RULE7: Table page bit 7 selects configuration space
// RULE8: No table writes into configuration space
// RULE9: Window needs address bit 15 and page bit 9
// RULE10: Window address joins page low byte, 15 bits
// RULE11: Read page bit 8 picks upper word
// RULE12: Upper data half windows a 16K-word page
// RULE13: Pages 200h-2FFh lower, 300h-3FFh upper words
// RULE14: Upper address with zero page traps
// RULE15: Program window is read only
// RULE16: Window read extra cycles outside repeat loop
// RULE17: Repeat loop edges cost two, others none
// RULE18: Otherwise plain data access, no redirection
module pda_bridge #(
  parameter int AXI_ADDR_W = 32
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic                 core_req_valid,
  output logic                      core_req_ready,
  input  wire pda_pkg::pda_req_t    core_req,
  output logic                      core_resp_valid,
  output pda_pkg::pda_resp_t        core_resp,
  output logic                      pm_req_valid,
  input  wire logic                 pm_ack,
  output pda_pkg::pda_pm_req_t      pm_req,
  input  wire logic [23:0]          pm_rdata,
  output logic                      irq
);

  localparam pda_pkg::pda_regs_t RESET_STATE = '{
    st:       pda_pkg::PDA_IDLE,
    tbl_page: `PDA_RST_TBL_PAGE,
    rd_page:  `PDA_RST_RD_PAGE,
    wr_page:  `PDA_RST_WR_PAGE,
    irq_sts:  `PDA_RST_IRQ,
    irq_mask: `PDA_RST_IRQ,
    default:  '0
  };

  // Offsets decode eight address bits and the held address is 32 bits wide
  if (AXI_ADDR_W < 8 || AXI_ADDR_W > 32)
  begin : g_addr_w_check
    $error("AXI_ADDR_W must lie between 8 and 32");
  end

  pda_pkg::pda_regs_t r_reg;
  pda_pkg::pda_regs_t r_next;

  // Byte lane merge for register writes
  function automatic logic [31:0] pda_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : pda_merge

  // Shapes a 24-bit program word into the 16-bit data answer
  function automatic logic [15:0] pda_format(
    input logic [23:0] pword,
    input logic        hi,
    input logic        bm,
    input logic        bs
  );
    logic [15:0] half;
    half = hi ? {8'h00, pword[23:16]} : pword[15:0]; // see RULE3 see RULE11
    if (!bm)
    begin
      return half; // see RULE1
    end
    return {8'h00, (bs ? half[15:8] : half[7:0])}; // see RULE2 see RULE4
  endfunction : pda_format

  // Hands back the answer and closes the request
  function automatic pda_pkg::pda_regs_t pda_finish(
    input pda_pkg::pda_regs_t s
  );
    pda_pkg::pda_regs_t o;
    o = s;
    o.st = pda_pkg::PDA_IDLE;
    o.resp_valid = 1'b1;
    return o;
  endfunction : pda_finish

  always_comb
  begin
    pda_pkg::pda_regs_t n;
    logic [1:0]         clr;
    logic [1:0]         ev;
    logic [7:0]         ofs;
    logic [22:0]        win_addr;
    logic [1:0]         extra;
    logic [31:0]        merged;
    n = r_reg;
    clr = 2'h0;
    ev = 2'h0;
    ofs = 8'h00;
    win_addr = 23'h0;
    extra = 2'h0;
    merged = 32'h0;
    n.resp_valid = 1'b0;

    // Register write channel: address and data in either order
    if (r_reg.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = 32'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (n.aw_got && n.w_got)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PDA_RESP_OKAY;
      ofs = n.awaddr[7:0];
      if (n.awaddr[31:8] != 24'h0)
      begin
        n.bresp = `PDA_RESP_SLVERR;
      end
      else
      begin
        case (ofs)
          `PDA_OFS_TBL_PAGE:
          begin
            merged = pda_merge({24'h0, r_reg.tbl_page}, n.wdata, n.wstrb);
            n.tbl_page = merged[7:0];
          end
          `PDA_OFS_RD_PAGE:
          begin
            merged = pda_merge({22'h0, r_reg.rd_page}, n.wdata, n.wstrb);
            n.rd_page = merged[9:0];
          end
          `PDA_OFS_WR_PAGE:
          begin
            merged = pda_merge({22'h0, r_reg.wr_page}, n.wdata, n.wstrb);
            n.wr_page = merged[9:0];
          end
          `PDA_OFS_IRQ_STS:
          begin
            clr = n.wstrb[0] ? n.wdata[1:0] : 2'h0;
          end
          `PDA_OFS_IRQ_MASK:
          begin
            merged = pda_merge({30'h0, r_reg.irq_mask}, n.wdata, n.wstrb);
            n.irq_mask = merged[1:0];
          end
          `PDA_OFS_STATE:
          begin
            n.bresp = `PDA_RESP_OKAY;
          end
          default:
          begin
            n.bresp = `PDA_RESP_SLVERR;
          end
        endcase
      end
    end

    // Register read channel
    if (r_reg.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = `PDA_RESP_OKAY;
      n.rdata = 32'h0;
      if (32'(s_axi_araddr) > 32'h0000_00FF)
      begin
        n.rresp = `PDA_RESP_SLVERR;
      end
      else
      begin
        case (s_axi_araddr[7:0])
          `PDA_OFS_TBL_PAGE: n.rdata = {24'h0, r_reg.tbl_page};
          `PDA_OFS_RD_PAGE:  n.rdata = {22'h0, r_reg.rd_page};
          `PDA_OFS_WR_PAGE:  n.rdata = {22'h0, r_reg.wr_page};
          `PDA_OFS_IRQ_STS:  n.rdata = {30'h0, r_reg.irq_sts};
          `PDA_OFS_IRQ_MASK: n.rdata = {30'h0, r_reg.irq_mask};
          `PDA_OFS_STATE:    n.rdata = {28'h0, r_reg.cnt, r_reg.st};
          default:           n.rresp = `PDA_RESP_SLVERR;
        endcase
      end
    end

    // Core side access engine
    case (r_reg.st)
      pda_pkg::PDA_IDLE:
      begin
        if (core_req_valid)
        begin
          n.resp = '0;
          n.bm = core_req.byte_mode;
          n.bs = core_req.ea[0];
          n.cnt = 2'h0;
          n.pm = '0;
          n.pm.cfg = r_reg.tbl_page[`PDA_TBL_CFG_BIT]; // see RULE7
          // Both halves sit at one word address, bit 0 only picks a byte
          n.pm.addr = {r_reg.tbl_page, core_req.ea[15:1], 1'b0}; // see RULE5 see RULE6
          case (core_req.kind)
            pda_pkg::PDA_TABLE_READ_LOW, pda_pkg::PDA_TABLE_READ_HIGH:
            begin
              n.hi = (core_req.kind == pda_pkg::PDA_TABLE_READ_HIGH);
              n.rd = 1'b1;
              n.pm_valid = 1'b1;
              n.st = pda_pkg::PDA_MEM;
            end
            pda_pkg::PDA_TABLE_WRITE_LOW, pda_pkg::PDA_TABLE_WRITE_HIGH:
            begin
              n.rd = 1'b0;
              if (r_reg.tbl_page[`PDA_TBL_CFG_BIT])
              begin
                // Identity words must never change, so the write is dropped
                n.resp.refused = 1'b1; // see RULE8
                ev[`PDA_IRQ_CFG_WR] = 1'b1;
                n = pda_finish(n);
              end
              else
              begin
                n.pm.we = 1'b1;
                n.pm_valid = 1'b1;
                n.st = pda_pkg::PDA_MEM;
                if (core_req.kind == pda_pkg::PDA_TABLE_WRITE_LOW)
                begin
                  n.pm.wdata = {8'h00, core_req.wdata};
                  n.pm.wstrb = !core_req.byte_mode ? 3'h3 : (core_req.ea[0] ? 3'h2 : 3'h1);
                  if (core_req.byte_mode)
                  begin
                    n.pm.wdata = {8'h00, core_req.wdata[7:0], core_req.wdata[7:0]};
                  end
                end
                else
                begin
                  // Phantom byte has no storage: no lane is enabled
                  n.pm.wdata = {core_req.wdata[7:0], 16'h0000};
                  n.pm.wstrb = (core_req.byte_mode && core_req.ea[0]) ? 3'h0 : 3'h4;
                end
              end
            end
            pda_pkg::PDA_DATA_READ:
            begin
              n.rd = 1'b1;
              if (!core_req.ea[`PDA_EA_WIN_BIT])
              begin
                n.resp.passthru = 1'b1; // see RULE18
                n = pda_finish(n);
              end
              else if (r_reg.rd_page == 10'h000)
              begin
                n.resp.trap = 1'b1; // see RULE14
                ev[`PDA_IRQ_TRAP] = 1'b1;
                n = pda_finish(n);
              end
              else if (!r_reg.rd_page[`PDA_RD_WIN_BIT])
              begin
                n.resp.passthru = 1'b1; // see RULE18
                n = pda_finish(n);
              end
              else
              begin
                // Any page 200h-3FFh: 16K words of one half of program memory
                win_addr = {r_reg.rd_page[7:0], core_req.ea[14:0]}; // see RULE9 see RULE10
                n.pm.addr = {1'b0, win_addr[22:1], 1'b0}; // see RULE12 see RULE13
                n.pm.cfg = 1'b0;
                n.hi = r_reg.rd_page[`PDA_RD_HI_BIT]; // see RULE11
                n.pm_valid = 1'b1;
                n.st = pda_pkg::PDA_MEM;
                if (!core_req.in_repeat)
                begin
                  extra = core_req.is_mov ? `PDA_EXTRA_MOV : `PDA_EXTRA_OTHER; // see RULE16
                end
                else
                begin
                  extra = core_req.repeat_edge ? `PDA_EXTRA_RPT_EDGE : `PDA_EXTRA_RPT_MID; // see RULE17
                end
                n.cnt = extra;
              end
            end
            pda_pkg::PDA_DATA_WRITE:
            begin
              n.rd = 1'b0;
              if (core_req.ea[`PDA_EA_WIN_BIT] && r_reg.wr_page == 10'h000)
              begin
                n.resp.trap = 1'b1; // see RULE14
                ev[`PDA_IRQ_TRAP] = 1'b1;
              end
              else
              begin
                // Writes never reach program memory through the window
                n.resp.passthru = 1'b1; // see RULE15
              end
              n = pda_finish(n);
            end
            default:
            begin
              n.resp.refused = 1'b1;
              n = pda_finish(n);
            end
          endcase
        end
      end
      pda_pkg::PDA_MEM:
      begin
        if (pm_ack)
        begin
          n.pm_valid = 1'b0;
          if (r_reg.rd)
          begin
            n.resp.data = pda_format(pm_rdata, r_reg.hi, r_reg.bm, r_reg.bs);
          end
          if (r_reg.cnt != 2'h0)
          begin
            n.st = pda_pkg::PDA_EXTRA;
          end
          else
          begin
            n = pda_finish(n);
          end
        end
      end
      pda_pkg::PDA_EXTRA:
      begin
        n.cnt = r_reg.cnt - 2'h1; // see RULE16 see RULE17
        if (r_reg.cnt == 2'h1)
        begin
          n = pda_finish(n);
        end
      end
      default:
      begin
        n.st = pda_pkg::PDA_IDLE;
      end
    endcase

    // A new event beats a clear written in the same cycle
    n.irq_sts = (r_reg.irq_sts & ~clr) | ev;
    r_next = n;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= RESET_STATE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready   = !r_reg.aw_got && !r_reg.bvalid;
  assign s_axi_wready    = !r_reg.w_got && !r_reg.bvalid;
  assign s_axi_bvalid    = r_reg.bvalid;
  assign s_axi_bresp     = r_reg.bresp;
  assign s_axi_arready   = !r_reg.rvalid;
  assign s_axi_rvalid    = r_reg.rvalid;
  assign s_axi_rdata     = r_reg.rdata;
  assign s_axi_rresp     = r_reg.rresp;
  assign core_req_ready  = (r_reg.st == pda_pkg::PDA_IDLE);
  assign core_resp_valid = r_reg.resp_valid;
  assign core_resp       = r_reg.resp;
  assign pm_req_valid    = r_reg.pm_valid;
  assign pm_req          = r_reg.pm;
  assign irq             = |(r_reg.irq_sts & r_reg.irq_mask);

endmodule : pda_bridge

`default_nettype wire

/* dv/pda_pm_model.sv */
/*
  Program memory model for the program space bridge: acks after lat cycles.
  Assumes each request is held until its ack.
*/
`default_nettype none
module pda_pm_model (
  input  wire logic                 aclk,
  input  wire logic                 pm_req_valid,
  input  wire pda_pkg::pda_pm_req_t pm_req,
  input  wire logic [3:0]           lat,
  output logic                      pm_ack,
  output logic [23:0]               pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]           cnt_reg;
  pda_pkg::pda_pm_req_t last_reg;
  function automatic logic [23:0] pword(input logic [23:0] a);
    return {a[8:1] ^ 8'hC3, a[16:1] ^ 16'h5A3C};
  endfunction : pword
  assign pm_ack = pm_req_valid && (cnt_reg >= lat);
  // Inverted outside ack, so a stale sample never looks right
  assign pm_rdata = pm_ack ? pword(pm_req.addr) : ~pword(pm_req.addr);
  always @(posedge aclk)
  begin
    cnt_reg <= (pm_req_valid && !pm_ack) ? cnt_reg + 4'h1 : 4'h0;
    if (pm_ack)
      last_reg <= pm_req;
  end
endmodule : pda_pm_model
`default_nettype wire

/* dv/pda_bridge_props.sv */
/*
  Checker for the program space bridge core and memory sides.
  Assumes it is bound to pda_bridge and sees its ports only.
*/
`default_nettype none
module pda_bridge_props (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 core_req_valid,
  input wire logic                 core_req_ready,
  input wire pda_pkg::pda_req_t    core_req,
  input wire logic                 core_resp_valid,
  input wire pda_pkg::pda_resp_t   core_resp,
  input wire logic                 pm_req_valid,
  input wire logic                 pm_ack,
  input wire pda_pkg::pda_pm_req_t pm_req,
  input wire logic [23:0]          pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic              take;
  logic              ack_rd;
  logic              win;
  pda_pkg::pda_req_t q_reg;
  logic [23:0]       pd_reg;
  assign take = core_req_valid && core_req_ready;
  assign ack_rd = pm_req_valid && pm_ack && !pm_req.we;
  assign win = ack_rd && q_reg.kind == pda_pkg::PDA_DATA_READ;
  always_ff @(posedge aclk)
  begin
    if (take)
      q_reg <= core_req;
    pd_reg <= pm_rdata;
  end
  sequence s_gap1;
    !core_resp_valid ##1 core_resp_valid;
  endsequence
  sequence s_gap2;
    !core_resp_valid [*2] ##1 core_resp_valid;
  endsequence
  a_pm_hold: assert property (pm_req_valid && !pm_ack |=> pm_req_valid && $stable(pm_req))
    else $error("memory request changed before ack");
  a_cfg_no_write: assert property (pm_req_valid && pm_req.cfg |-> !pm_req.we)
    else $error("write issued into configuration space");
  a_even_addr: assert property (pm_req_valid |-> !pm_req.addr[0])
    else $error("odd program address");
  a_low_passthru: assert property (take && core_req.kind == pda_pkg::PDA_DATA_READ
    && !core_req.ea[15] |=> core_resp_valid && core_resp.passthru)
    else $error("low data read not passed through");
  a_win_addr: assert property (take && core_req.kind == pda_pkg::PDA_DATA_READ |=>
    !pm_req_valid || (!pm_req.we && !pm_req.addr[23] && pm_req.addr[14:1] == q_reg.ea[14:1]))
    else $error("window address or direction wrong");
  a_tbl_low: assert property (ack_rd && q_reg.kind == pda_pkg::PDA_TABLE_READ_LOW
    && !q_reg.byte_mode |=> core_resp_valid && core_resp.data == pd_reg[15:0])
    else $error("word low table read data wrong");
  a_tbl_high: assert property (ack_rd && q_reg.kind == pda_pkg::PDA_TABLE_READ_HIGH
    && !q_reg.byte_mode |=> core_resp_valid && core_resp.data == {8'h00, pd_reg[23:16]})
    else $error("word high table read data wrong");
  a_win_mov: assert property (win && !q_reg.in_repeat && q_reg.is_mov |=> s_gap1)
    else $error("move window read not one extra cycle");
  a_win_other: assert property (win && !q_reg.in_repeat && !q_reg.is_mov |=> s_gap2)
    else $error("other window read not two extra cycles");
  a_rpt_edge: assert property (win && q_reg.in_repeat && q_reg.repeat_edge |=> s_gap2)
    else $error("repeat edge read not two extra cycles");
  a_rpt_mid: assert property (win && q_reg.in_repeat && !q_reg.repeat_edge |=> core_resp_valid)
    else $error("repeat middle read delayed");
endmodule : pda_bridge_props
bind pda_bridge pda_bridge_props u_props (.*);
`default_nettype wire

/* dv/tb_program_space_data_access.sv */
/*
  Testbench for the program space bridge: AXI registers, table and window reads.
  Assumes pda_pm_model stands in for program memory.
*/
`default_nettype none
module tb_program_space_data_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic core_req_valid, core_req_ready, core_resp_valid, pm_req_valid, pm_ack, irq;
  logic [31:0]          s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]           s_axi_wstrb, lat;
  logic [1:0]           s_axi_bresp, s_axi_rresp, rr;
  logic [23:0]          pm_rdata;
  pda_pkg::pda_req_t    core_req;
  pda_pkg::pda_resp_t   core_resp;
  pda_pkg::pda_pm_req_t pm_req;
  int                   bad_count, num_checks;
  pda_bridge dut (.*);
  pda_pm_model pm (.*);
  always #5 aclk = ~aclk;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200)
    begin
      bad_count++;
      $display("MISMATCH %0t wait limit reached", $time);
      results();
    end
  endtask : tick
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int   n = 0;
    logic aw_d = 1'b0;
    logic w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      tick(n);
      aw_d = aw_d | s_axi_awready;
      w_d = w_d | s_axi_wready;
      s_axi_awvalid <= !aw_d;
      s_axi_wvalid <= !w_d;
    end
    while (!(aw_d && w_d));
    s_axi_bready <= 1'b1;
    do tick(n);
    while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [31:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(n);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do tick(n);
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // Request held until taken, then wait for the answer pulse
  task automatic op(input pda_pkg::pda_kind_t k, input logic [16:0] be, input logic [2:0] fl);
    int n = 0;
    core_req <= {k, be, 16'hBEEF, fl};
    core_req_valid <= 1'b1;
    do tick(n);
    while (!core_req_ready);
    core_req_valid <= 1'b0;
    do tick(n);
    while (!core_resp_valid);
  endtask : op
  function automatic logic [15:0] fmt(input logic [23:0] p, input logic hi, bm, bs);
    logic [15:0] h;
    h = hi ? {8'h00, p[23:16]} : p[15:0];
    return bm ? {8'h00, bs ? h[15:8] : h[7:0]} : h;
  endfunction : fmt
  task automatic t_regs();
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(i * 4);
      chk(rd, 32'h0);
    end
    wr(32'h04, 32'hFFFFFFFF);
    rd_reg(32'h04);
    chk(rd, 32'h3FF);
    wr(32'h18, 32'h1);
    chk(rr, 2'h2);
    rd_reg(32'h18);
    chk({rd[29:0], rr}, 32'h2);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_table();
    wr(32'h00, 32'h12);
    lat <= 4'h3;
    for (int i = 0; i < 8; i++)
    begin
      if (!i[1] && i[0])
        continue;
      op(i[2] ? pda_pkg::PDA_TABLE_READ_HIGH : pda_pkg::PDA_TABLE_READ_LOW,
         {i[1], 15'h091A, i[0]}, 3'h0);
      chk(pm.last_reg.addr, 24'h121234);
      chk(pm.last_reg.cfg, 1'b0);
      chk(core_resp.data, fmt(pm.pword(24'h121234), i[2], i[1], i[0]));
    end
    lat <= 4'h0;
    for (int i = 0; i < 2; i++)
    begin
      op(i[0] ? pda_pkg::PDA_TABLE_WRITE_HIGH : pda_pkg::PDA_TABLE_WRITE_LOW, 17'h10, 3'h0);
      chk({pm.last_reg.we, pm.last_reg.wstrb}, i[0] ? 4'hC : 4'hB);
      chk(pm.last_reg.addr, 24'h120010);
      chk(pm.last_reg.wdata, i[0] ? 24'hEF0000 : 24'h00BEEF);
    end
    op(pda_pkg::PDA_TABLE_WRITE_LOW, 17'h10011, 3'h0);
    chk({pm.last_reg.wstrb, pm.last_reg.wdata}, 27'h200EFEF);
    op(pda_pkg::PDA_TABLE_WRITE_HIGH, 17'h10011, 3'h0);
    chk({pm.last_reg.we, pm.last_reg.wstrb}, 4'h8);
    $display("t_table done");
  endtask : t_table
  task automatic t_cfg();
    wr(32'h00, 32'h80);
    op(pda_pkg::PDA_TABLE_READ_LOW, 17'h6, 3'h0);
    chk({pm.last_reg.cfg, pm.last_reg.addr}, 25'h1800006);
    op(pda_pkg::PDA_TABLE_WRITE_LOW, 17'h6, 3'h0);
    chk(core_resp.refused, 1'b1);
    chk(irq, 1'b0);
    wr(32'h10, 32'h3);
    chk(irq, 1'b1);
    rd_reg(32'h0C);
    chk(rd, 32'h2);
    wr(32'h0C, 32'h2);
    chk(irq, 1'b0);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_win();
    logic [23:0] a;
    logic [2:0]  fl [4] = '{3'h4, 3'h0, 3'h3, 3'h2};
    wr(32'h04, 32'h202);
    a = {1'b0, 8'h02, 14'h0005, 1'b0};
    foreach (fl[i])
    begin
      op(pda_pkg::PDA_DATA_READ, {1'b0, 16'h800A}, fl[i]);
      chk(pm.last_reg.addr, a);
      chk(core_resp.data, fmt(pm.pword(a), 1'b0, 1'b0, 1'b0));
    end
    op(pda_pkg::PDA_DATA_READ, {1'b1, 16'h800B}, 3'h4);
    chk(core_resp.data, fmt(pm.pword(a), 1'b0, 1'b1, 1'b1));
    wr(32'h04, 32'h3FF);
    op(pda_pkg::PDA_DATA_READ, {1'b0, 16'hFFFE}, 3'h0);
    a = {1'b0, 8'hFF, 14'h3FFF, 1'b0};
    chk(core_resp.data, fmt(pm.pword(a), 1'b1, 1'b0, 1'b0));
    chk(pm.last_reg.addr, a);
    op(pda_pkg::PDA_DATA_READ, {1'b0, 16'h0123}, 3'h0);
    chk(core_resp.passthru, 1'b1);
    wr(32'h04, 32'h102);
    op(pda_pkg::PDA_DATA_READ, {1'b0, 16'h800A}, 3'h0);
    chk({core_resp.passthru, core_resp.trap}, 2'h2);
    wr(32'h04, 32'h0);
    op(pda_pkg::PDA_DATA_READ, {1'b0, 16'h8002}, 3'h0);
    chk(core_resp.trap, 1'b1);
    op(pda_pkg::PDA_DATA_WRITE, {1'b0, 16'h8002}, 3'h0);
    chk(core_resp.trap, 1'b1);
    rd_reg(32'h0C);
    chk(rd, 32'h1);
    wr(32'h08, 32'h5);
    op(pda_pkg::PDA_DATA_WRITE, {1'b0, 16'h8002}, 3'h0);
    chk({core_resp.passthru, core_resp.trap}, 2'h2);
    $display("t_win done");
  endtask : t_win
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, lat} = '0;
    core_req_valid = 1'b0;
    core_req = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_table();
    t_cfg();
    t_win();
    results();
  end
endmodule : tb_program_space_data_access
`default_nettype wire
